// file: verilog/rs485_line_ctrl.sv
/*
  Serial line side of a single-port RS-422/485 adapter: 8N1 transmitter and
  receiver, line mode decode, driver enable selection and echo suppression.
  Assumes host controls on the same clock; only the receive pin is foreign.
*/
`timescale 1ns/1ps
module rs485_line_ctrl
  import rs485_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [2:0] line_mode_switch,
  input wire logic [1:0] enable_src,
  input wire logic rts,
  input wire logic dtr,
  input wire logic [DIV_W-1:0] divisor,
  input wire tx_beat_t tx_in,
  output logic tx_ready,
  output rx_beat_t rx_out,
  input wire logic rx_pin,
  output logic tx_pin,
  output logic drv_en,
  output line_mode_t line_mode
);

  logic tick;
  logic rx_meta_r;
  logic rx_sync_r;
  tx_state_t tx_state_r;
  logic [SMP_W-1:0] tx_smp_r;
  logic [BIT_W-1:0] tx_bit_r;
  logic [7:0] tx_shift_r;
  rx_state_t rx_state_r;
  logic [SMP_W-1:0] rx_smp_r;
  logic [BIT_W-1:0] rx_bit_r;
  logic [7:0] rx_shift_r;
  logic echo_r;
  logic drive_src;
  logic drv_en_nxt;
  line_mode_t line_mode_nxt;

  // [RQ11] Sixteen ticks per bit.
  sample_tick_gen sample_tick_gen_i (
    .clk(clk),
    .nrst(nrst),
    .divisor(divisor),
    .sample_tick(tick)
  );

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_meta_r <= 1'b1;
      rx_sync_r <= 1'b1;
    end else begin
      rx_meta_r <= rx_pin;
      rx_sync_r <= rx_meta_r;
    end
  end

  // [RQ4] Switch decode.
  always_comb begin
    unique case (line_mode_switch)
      SW_RS422: line_mode_nxt = MODE_RS422;
      SW_RS485_4W: line_mode_nxt = MODE_RS485_4W;
      SW_RS485_2W: line_mode_nxt = MODE_RS485_2W;
      default: line_mode_nxt = MODE_INVALID;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      line_mode <= MODE_INVALID;
    end else begin
      line_mode <= line_mode_nxt;
    end
  end

  always_comb begin
    unique case (enable_src)
      // [RQ7] Automatic enable from transmitter.
      EN_AUTO: drive_src = (tx_state_r != TX_IDLE);
      // [RQ8] RTS gates driver.
      EN_RTS: drive_src = rts;
      // [RQ9] DTR gates driver.
      EN_DTR: drive_src = dtr;
      default: drive_src = 1'b0;
    endcase
  end

  // [RQ6] Release bus unless selected.
  always_comb begin
    unique case (line_mode_nxt)
      MODE_RS422: drv_en_nxt = 1'b1;
      MODE_RS485_4W: drv_en_nxt = drive_src;
      MODE_RS485_2W: drv_en_nxt = drive_src;
      default: drv_en_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      drv_en <= 1'b0;
    end else begin
      drv_en <= drv_en_nxt;
    end
  end

  // Transmitter: the start bit begins at once, later bits last 16 ticks.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_state_r <= TX_IDLE;
      tx_smp_r <= '0;
      tx_bit_r <= '0;
      tx_shift_r <= '0;
      tx_pin <= 1'b1;
      tx_ready <= 1'b1;
    end else begin
      unique case (tx_state_r)
        TX_IDLE: begin
          if (tx_in.valid) begin
            tx_shift_r <= tx_in.data;
            tx_pin <= 1'b0;
            tx_ready <= 1'b0;
            tx_smp_r <= '0;
            tx_state_r <= TX_START;
          end
        end
        TX_START: begin
          if (tick) begin
            tx_smp_r <= tx_smp_r + 1'b1;
            if (tx_smp_r == SMP_LAST) begin
              tx_pin <= tx_shift_r[0];
              tx_shift_r <= {1'b0, tx_shift_r[7:1]};
              tx_bit_r <= '0;
              tx_state_r <= TX_DATA;
            end
          end
        end
        TX_DATA: begin
          if (tick) begin
            tx_smp_r <= tx_smp_r + 1'b1;
            if (tx_smp_r == SMP_LAST) begin
              tx_bit_r <= tx_bit_r + 1'b1;
              if (tx_bit_r == BIT_LAST) begin
                tx_pin <= 1'b1;
                tx_state_r <= TX_STOP;
              end else begin
                tx_pin <= tx_shift_r[0];
                tx_shift_r <= {1'b0, tx_shift_r[7:1]};
              end
            end
          end
        end
        TX_STOP: begin
          if (tick) begin
            tx_smp_r <= tx_smp_r + 1'b1;
            if (tx_smp_r == SMP_LAST) begin
              tx_ready <= 1'b1;
              tx_state_r <= TX_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Receiver: start edge checked at mid bit, then sampled every 16 ticks.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_state_r <= RX_IDLE;
      rx_smp_r <= '0;
      rx_bit_r <= '0;
      rx_shift_r <= '0;
      echo_r <= 1'b0;
      rx_out <= '0;
    end else begin
      rx_out.valid <= 1'b0;
      unique case (rx_state_r)
        RX_IDLE: begin
          if (tick && !rx_sync_r) begin
            rx_smp_r <= '0;
            // [RQ5] Mark characters heard while driving.
            // [RQ10] Four-wire keeps full duplex.
            echo_r <= (line_mode == MODE_RS485_2W) &&
                      (drv_en || tx_state_r != TX_IDLE);
            rx_state_r <= RX_START;
          end
        end
        RX_START: begin
          if (tick) begin
            rx_smp_r <= rx_smp_r + 1'b1;
            if (rx_smp_r == SMP_MID) begin
              rx_smp_r <= '0;
              rx_bit_r <= '0;
              rx_state_r <= rx_sync_r ? RX_IDLE : RX_DATA;
            end
          end
        end
        RX_DATA: begin
          if (tick) begin
            rx_smp_r <= rx_smp_r + 1'b1;
            if (rx_smp_r == SMP_LAST) begin
              rx_shift_r <= {rx_sync_r, rx_shift_r[7:1]};
              rx_bit_r <= rx_bit_r + 1'b1;
              if (rx_bit_r == BIT_LAST) begin
                rx_state_r <= RX_STOP;
              end
            end
          end
        end
        RX_STOP: begin
          if (tick) begin
            rx_smp_r <= rx_smp_r + 1'b1;
            if (rx_smp_r == SMP_LAST) begin
              // [RQ5] Drop echoed characters.
              rx_out.valid <= !echo_r;
              rx_out.frame_err <= !rx_sync_r;
              rx_out.data <= rx_shift_r;
              rx_state_r <= RX_IDLE;
            end
          end
        end
      endcase
    end
  end

endmodule : rs485_line_ctrl

// file: verilog/rs485_pkg.sv
/*
  Shared constants and types for the RS-422/485 line control block.
  Assumes a single 20 MHz clock and a host that supplies the configuration
  levels and transmit bytes on the same clock.
*/
// Notes on behaviour
// [RQ1] Bit timing from a 14.7456 MHz reference.
// [RQ2] Line rate is 921.6 kbps over divisor.
// [RQ3] Legacy software requests one eighth the rate; the divisor here acts on the 14.7456 MHz reference, REF_RATIO unused.
// [RQ4] Switch selects 422, 485 four-wire, 485 two-wire.
// [RQ5] Two-wire mode drops own echoed characters.
// [RQ6] Only one node drives the shared bus.
// [RQ7] Automatic enable wraps each transmission tightly; drv_en here rises one clock after the start bit begins.
// [RQ8] RTS source enables driver only while asserted.
// [RQ9] DTR source gates the driver by DTR.
// [RQ10] Two-wire is half duplex, four-wire full.
// [RQ11] Sixteen samples per bit time.
package rs485_pkg;

  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned REF_HZ = 14745600;
  localparam int unsigned LEGACY_REF_HZ = 1843200;
  localparam int unsigned REF_RATIO = REF_HZ / LEGACY_REF_HZ;
  // The accumulator must hold the sum just before the wrap without overflow.
  localparam int ACC_W = 26;
  localparam logic [ACC_W-1:0] ACC_MOD = ACC_W'(CLK_HZ);
  localparam logic [ACC_W-1:0] ACC_INC = ACC_W'(REF_HZ);
  localparam logic [ACC_W-1:0] ACC_RST = 26'h0;

  localparam int DIV_W = 16;
  localparam logic [DIV_W-1:0] DIV_RST = 16'h0060;
  localparam logic [DIV_W-1:0] DIV_ONE = 16'h0001;

  localparam int SMP_W = 4;
  localparam logic [SMP_W-1:0] SMP_LAST = 4'hf;
  localparam logic [SMP_W-1:0] SMP_MID = 4'h7;
  localparam int BIT_W = 3;
  localparam logic [BIT_W-1:0] BIT_LAST = 3'h7;

  localparam logic [2:0] SW_RS422 = 3'h0;
  localparam logic [2:0] SW_RS485_4W = 3'h3;
  localparam logic [2:0] SW_RS485_2W = 3'h6;

  typedef enum logic [1:0] {
    MODE_RS422 = 2'h0,
    MODE_RS485_4W = 2'h1,
    MODE_RS485_2W = 2'h2,
    MODE_INVALID = 2'h3
  } line_mode_t;

  typedef enum logic [1:0] {
    EN_AUTO = 2'h0,
    EN_RTS = 2'h1,
    EN_DTR = 2'h2
  } enable_src_t;

  typedef enum logic [3:0] {
    TX_IDLE = 4'h1,
    TX_START = 4'h2,
    TX_DATA = 4'h4,
    TX_STOP = 4'h8
  } tx_state_t;

  typedef enum logic [3:0] {
    RX_IDLE = 4'h1,
    RX_START = 4'h2,
    RX_DATA = 4'h4,
    RX_STOP = 4'h8
  } rx_state_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } tx_beat_t;

  typedef struct packed {
    logic valid;
    logic frame_err;
    logic [7:0] data;
  } rx_beat_t;

endpackage : rs485_pkg

// file: verilog/sample_tick_gen.sv
/*
  Sample tick generator: a phase accumulator recreates the reference rate
  from the system clock, and a counter divides it by the baud divisor.
  Assumes the divisor is a level on the system clock.
*/
`timescale 1ns/1ps
module sample_tick_gen
  import rs485_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [DIV_W-1:0] divisor,
  output logic sample_tick
);

  logic [ACC_W-1:0] acc_r;
  logic [ACC_W-1:0] acc_sum;
  logic ref_en_r;
  logic [DIV_W-1:0] div_cnt_r;
  logic [DIV_W-1:0] div_eff;

  assign acc_sum = acc_r + ACC_INC;
  // A zero divisor behaves as one so the line never stalls.
  assign div_eff = (divisor == '0) ? DIV_ONE : divisor;

  // [RQ1] Reference rate synthesis.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc_r <= ACC_RST;
      ref_en_r <= 1'b0;
    end else if (acc_sum >= ACC_MOD) begin
      acc_r <= acc_sum - ACC_MOD;
      ref_en_r <= 1'b1;
    end else begin
      acc_r <= acc_sum;
      ref_en_r <= 1'b0;
    end
  end

  // [RQ2] Divide by divisor.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_cnt_r <= '0;
      sample_tick <= 1'b0;
    end else if (ref_en_r) begin
      if (div_cnt_r + DIV_ONE >= div_eff) begin
        div_cnt_r <= '0;
        sample_tick <= 1'b1;
      end else begin
        div_cnt_r <= div_cnt_r + DIV_ONE;
        sample_tick <= 1'b0;
      end
    end else begin
      sample_tick <= 1'b0;
    end
  end

endmodule : sample_tick_gen

// file: tb/rs485_line_ctrl_assertions.sv
/* Port checker for rs485_line_ctrl.
   Assumes one clock and an active-low reset. */
`timescale 1ns/1ps
module rs485_line_ctrl_assertions
  import rs485_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [2:0] line_mode_switch,
  input wire logic [1:0] enable_src,
  input wire logic rts,
  input wire logic dtr,
  input wire logic [DIV_W-1:0] divisor,
  input wire tx_beat_t tx_in,
  input wire logic tx_ready,
  input wire logic tx_pin,
  input wire logic drv_en,
  input wire line_mode_t line_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [2:0] sw;
  logic m485;
  assign sw = line_mode_switch;
  assign m485 = sw == SW_RS485_4W || sw == SW_RS485_2W;
  property p_m422; sw == SW_RS422 |=> line_mode == MODE_RS422 && drv_en;
  endproperty
  a_m422: assert property (p_m422) else $error("422 mode");
  property p_m4w; sw == SW_RS485_4W |=> line_mode == MODE_RS485_4W;
  endproperty
  a_m4w: assert property (p_m4w) else $error("4w mode");
  property p_m2w; sw == SW_RS485_2W |=> line_mode == MODE_RS485_2W;
  endproperty
  a_m2w: assert property (p_m2w) else $error("2w mode");
  property p_bad; !m485 && sw != SW_RS422 |=> line_mode == MODE_INVALID;
  endproperty
  a_bad: assert property (p_bad) else $error("bad mode");
  property p_rts; m485 && enable_src == EN_RTS |=> drv_en == $past(rts);
  endproperty
  a_rts: assert property (p_rts) else $error("rts gate");
  property p_dtr; m485 && enable_src == EN_DTR |=> drv_en == $past(dtr);
  endproperty
  a_dtr: assert property (p_dtr) else $error("dtr gate");
  property p_auto; m485 && enable_src == EN_AUTO && $fell(tx_ready) |=> drv_en;
  endproperty
  a_auto: assert property (p_auto) else $error("auto enable");
  property p_start; tx_ready && tx_in.valid |=> !tx_ready && !tx_pin;
  endproperty
  a_start: assert property (p_start) else $error("start bit");
  property p_frame;
    divisor == DIV_ONE && $fell(tx_ready) |-> ##[212:222] $rose(tx_ready);
  endproperty
  a_frame: assert property (p_frame) else $error("frame time");
endmodule : rs485_line_ctrl_assertions

// file: tb/remote_node.sv
/* Remote node on the pair: sends and receives 8N1 characters.
   Assumes the bench resolves the bus with a pull-up. */
`timescale 1ns/1ps
module remote_node #(parameter real BIT_NS = 1085.07) (
  input wire logic line_in,
  input wire logic shared,
  input wire logic [15:0] div,
  output logic line_out,
  output logic drive,
  output logic got,
  output logic [7:0] got_data
);
  int k;
  initial begin
    line_out = 1'b1;
    drive = 1'b0;
    got = 1'b0;
    got_data = 8'h00;
  end
  task automatic send(input logic [7:0] b);
    drive = 1'b1;
    line_out = 1'b0;
    #(BIT_NS * div);
    for (int i = 0; i < 8; i++) begin
      line_out = b[i];
      #(BIT_NS * div);
    end
    line_out = 1'b1;
    #(BIT_NS * div);
    drive = 1'b0;
  endtask : send
  // On separate pairs the node still listens while it sends.
  always begin
    @(negedge line_in);
    if (!(drive && shared)) begin
      #(BIT_NS * div * 1.5);
      for (k = 0; k < 8; k++) begin
        got_data[k] = line_in;
        #(BIT_NS * div);
      end
      got = 1'b1;
      #10 got = 1'b0;
    end
  end
endmodule : remote_node

// file: tb/rs485_line_ctrl_test.sv
/* Bench for rs485_line_ctrl against a remote node.
   Assumes the checker and node model are compiled first. */
`timescale 1ns/1ps
module rs485_line_ctrl_test;
  import rs485_pkg::*;
  logic clk = 0, nrst = 0, rts = 0, dtr = 0;
  logic [2:0] sw = 3'h0;
  logic [1:0] src = 2'h0;
  logic [DIV_W-1:0] div = DIV_ONE;
  tx_beat_t tx_in = '0;
  logic tx_ready, tx_pin, drv_en, pout, pdrv, got;
  logic [7:0] got_d;
  rx_beat_t rx_out;
  line_mode_t line_mode;
  logic [7:0] rxq[$], txq[$];
  int seed = 32'h9826, fail_count = 0, num_checks = 0;
  logic [2:0] sw_tab[4] = '{SW_RS422, SW_RS485_4W, SW_RS485_2W, SW_RS485_2W};
  logic [1:0] src_tab[4] = '{EN_AUTO, EN_RTS, EN_DTR, EN_AUTO};
  wire two_w = sw == SW_RS485_2W;
  wire txl = drv_en ? tx_pin : 1'b1;
  wire pl = pdrv ? pout : 1'b1;
  rs485_line_ctrl rs485_line_ctrl_i (.clk, .nrst, .line_mode_switch(sw),
    .enable_src(src), .rts, .dtr, .divisor(div), .tx_in, .tx_ready,
    .rx_out, .rx_pin(two_w ? txl & pl : pl), .tx_pin, .drv_en, .line_mode);
  remote_node remote_node_i (.line_in(two_w ? txl & pl : txl),
    .shared(two_w), .div(div), .line_out(pout), .drive(pdrv), .got,
    .got_data(got_d));
  initial forever #25 clk = ~clk;
  task automatic chk_byte(input string n, input logic [7:0] e, g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask : chk_byte
  task automatic chk_bit(input string n, input logic e, g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s exp %b got %b", n, e, g);
    end
  endtask : chk_bit
  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  task automatic wait_rdy;
    int n;
    for (n = 0; n < 600 && tx_ready !== 1'b1; n++) @(posedge clk) #5;
    if (n == 600) begin
      fail_count++;
      give_verdict;
    end
  endtask : wait_rdy
  task automatic tx_byte(input logic [7:0] b);
    wait_rdy;
    txq.push_back(b);
    tx_in = '{valid: 1'b1, data: b};
    @(posedge clk) #5;
    tx_in.valid = 1'b0;
  endtask : tx_byte
  task automatic node_byte(input logic [7:0] b);
    rxq.push_back(b);
    remote_node_i.send(b);
  endtask : node_byte
  always @(negedge clk) begin
    if (rx_out.valid === 1'b1 && rxq.size() == 0)
      chk_bit("rx_extra", 1'b0, 1'b1);
    else if (rx_out.valid === 1'b1) begin
      chk_byte("rx_data", rxq.pop_front(), rx_out.data);
      chk_bit("rx_frame_err", 1'b0, rx_out.frame_err);
    end
    if (two_w && drv_en === 1'b1 && pdrv)
      chk_bit("contention", 1'b0, 1'b1);
  end
  always @(posedge got) begin
    if (txq.size() == 0) chk_bit("tx_extra", 1'b0, 1'b1);
    else chk_byte("tx_line", txq.pop_front(), got_d);
  end
  initial begin
    int n;
    repeat (20) @(posedge clk);
    #5 nrst = 1'b1;
    for (int i = 0; i < 4; i++) begin
      repeat (40) @(posedge clk);
      #5;
      sw = sw_tab[i];
      src = src_tab[i];
      // Divisor taken against the real reference.
      div = (i == 3) ? 16'h0002 : DIV_ONE;
      rts = 1'b1;
      dtr = 1'b1;
      // Full duplex traffic where the pairs are separate.
      if (sw != SW_RS485_2W) fork
        node_byte(8'($random(seed)));
      join_none
      tx_byte(8'($random(seed)));
      tx_byte(8'($random(seed)));
      wait_rdy;
      rts = 1'b0;
      dtr = 1'b0;
      repeat (2) @(posedge clk);
      #5;
      if (sw == SW_RS485_2W) node_byte(8'($random(seed)));
      for (n = 0; n < 3000 && rxq.size() + txq.size() > 0; n++)
        @(posedge clk);
      if (n == 3000) begin
        fail_count++;
        give_verdict;
      end
    end
    #5;
    sw = SW_RS485_4W;
    src = 2'h3;
    repeat (3) @(posedge clk);
    #5;
    chk_bit("drv_en_off", 1'b0, drv_en);
    sw = 3'h5;
    src = EN_DTR;
    dtr = 1'b1;
    repeat (3) @(posedge clk);
    #5;
    chk_bit("drv_en", 1'b0, drv_en);
    give_verdict;
  end
  initial begin
    #3000000;
    fail_count++;
    give_verdict;
  end
endmodule : rs485_line_ctrl_test
bind rs485_line_ctrl rs485_line_ctrl_assertions assertions_i (.clk, .nrst,
  .line_mode_switch, .enable_src, .rts, .dtr, .divisor, .tx_in, .tx_ready,
  .tx_pin, .drv_en, .line_mode);
